// ===== src/sensor_value_alarm.sv
// Purpose: Corrected sensor value, safe-state substitution, alarm/warning status.
// Assumes: Services are posted over APB; object state comes from a supervisor.
// Notes: One wait state on every APB access; services complete with the access.
`timescale 1ns/10ps
`default_nettype none

module sensor_value_alarm
  import sensor_value_pkg::*;
#(
  parameter int TICK_CYCLES = SETTLE_TICK_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] SENSOR_READING,
  input wire logic SENSOR_VALID,
  input wire logic OBJ_EXECUTING,
  input wire logic OBJ_IDLE,
  input wire logic IO_CONN_EST,
  output logic [31:0] VALUE_OUT,
  output logic [7:0] STATUS_OUT
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] sat16(input logic signed [33:0] x);
    if (x > 34'sh0_7fff) begin
      return 16'sh7fff;
    end else if (x < -34'sh0_8000) begin
      return 16'sh8000;
    end
    return x[15:0];
  endfunction : sat16

  // Integer to single precision; exact for every 16-bit input
  function automatic logic [31:0] to_real(input logic signed [15:0] v);
    logic [15:0] mag;
    logic [4:0] msb;
    logic [38:0] shifted;
    mag = v[15] ? 16'(-v) : v;
    msb = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (mag[i]) begin
        msb = 5'(i);
      end
    end
    shifted = 39'(mag) << (5'd23 - msb);
    if (mag == 16'h0000) begin
      return 32'h0000_0000;
    end
    return {v[15], 8'(8'd127 + 8'(msb)), shifted[22:0]};
  endfunction : to_real

  function automatic logic [31:0] encode(input logic [7:0] dt, input logic signed [15:0] v);
    return (dt == DTYPE_REAL) ? to_real(v) : {{16{v[15]}}, v};
  endfunction : encode

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] data_type;
  logic [15:0] units;
  logic alarm_en;
  logic warn_en;
  logic signed [15:0] offset_a;
  logic signed [15:0] offset_b;
  logic signed [15:0] gain;
  logic signed [15:0] trip [4];
  logic [15:0] hyst;
  logic [15:0] settle;
  logic [7:0] safe_state;
  logic signed [15:0] safe_value;
  logic [31:0] svc_wdata;
  logic [7:0] resp_code;
  logic [31:0] resp_data;
  logic signed [15:0] reported;
  logic [3:0] flag;
  logic [15:0] dwell [4];
  logic [15:0] tick_cnt;
  logic tick;

  logic apb_done;
  logic cmd_write;
  logic [7:0] cmd_code;
  logic [7:0] cmd_attr;
  logic signed [16:0] sum_in;
  logic signed [32:0] product;
  logic signed [15:0] corrected;
  logic signed [15:0] next_reported;
  logic [3:0] beyond;
  logic [3:0] clear_ok;
  logic [3:0] chan_en;
  logic [31:0] get_data;
  logic [7:0] get_code;

  assign apb_done = PSEL && PENABLE && PREADY;
  assign cmd_write = apb_done && PWRITE && (PADDR == OFF_SVC_CMD);
  assign cmd_code = PWDATA[7:0];
  assign cmd_attr = PWDATA[15:8];

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      if (PSEL && PENABLE && !PREADY) begin
        case (PADDR)
          OFF_SVC_CMD, OFF_SVC_WDATA: PRDATA <= 32'h0000_0000;
          OFF_SVC_RESP: PRDATA <= {24'h00_0000, resp_code};
          OFF_SVC_RDATA: PRDATA <= resp_data;
          OFF_VALUE: PRDATA <= VALUE_OUT;
          OFF_STATUS: PRDATA <= {24'h00_0000, STATUS_OUT};
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      svc_wdata <= 32'h0000_0000;
    end else if (apb_done && PWRITE && PADDR == OFF_SVC_WDATA) begin
      svc_wdata <= PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // Correction and safe state
  // ----------------------------------------------------------------
  always_comb begin
    sum_in = 17'($signed(SENSOR_READING)) + 17'(offset_a);
    product = 33'(sum_in) * 33'(gain);
    corrected = sat16(34'(product >>> GAIN_FRAC_BITS) + 34'(offset_b));
    if (OBJ_EXECUTING) begin
      next_reported = corrected;
    end else begin
      case (safe_state)
        SAFE_ZERO: next_reported = 16'sh0000;
        SAFE_FULL: next_reported = FULL_SCALE_INT;
        SAFE_HOLD: next_reported = reported;
        SAFE_USE_VALUE: next_reported = safe_value;
        default: next_reported = reported;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      reported <= 16'sh0000;
      VALUE_OUT <= 32'h0000_0000;
    end else begin
      reported <= next_reported;
      VALUE_OUT <= encode(data_type, next_reported);
    end
  end

  // ----------------------------------------------------------------
  // Settling time base
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 16'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Exceptions: 0 high alarm, 1 low alarm, 2 high warning, 3 low warning
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) begin
        beyond[i] = corrected > trip[i];
        clear_ok[i] = 18'(corrected) < (18'(trip[i]) - $signed({2'b00, hyst}));
      end else begin
        beyond[i] = corrected < trip[i];
        clear_ok[i] = 18'(corrected) > (18'(trip[i]) + $signed({2'b00, hyst}));
      end
    end
    chan_en = {warn_en, warn_en, alarm_en, alarm_en};
  end

  // Dwell counts whole ticks; phase of the free-running tick adds up to one unit of slack
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      flag <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        dwell[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!chan_en[i]) begin
          flag[i] <= 1'b0;
          dwell[i] <= 16'h0000;
        end else if (flag[i] ? !clear_ok[i] : !beyond[i]) begin
          dwell[i] <= 16'h0000;
        end else if (dwell[i] >= settle) begin
          flag[i] <= !flag[i];
          dwell[i] <= 16'h0000;
        end else if (tick) begin
          dwell[i] <= dwell[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      STATUS_OUT <= 8'h00;
    end else begin
      STATUS_OUT <= {4'h0, flag};
    end
  end

  // ----------------------------------------------------------------
  // Attribute read for the get service
  // ----------------------------------------------------------------
  always_comb begin
    get_code = RESP_OK;
    case (cmd_attr)
      ATTR_DATA_TYPE: get_data = {24'h00_0000, data_type};
      ATTR_UNITS: get_data = {16'h0000, units};
      ATTR_READ_VALID: get_data = {31'h0000_0000, SENSOR_VALID};
      ATTR_VALUE: get_data = VALUE_OUT;
      ATTR_STATUS: get_data = {24'h00_0000, STATUS_OUT};
      ATTR_ALARM_EN: get_data = {31'h0000_0000, alarm_en};
      ATTR_WARN_EN: get_data = {31'h0000_0000, warn_en};
      ATTR_FULL_SCALE: get_data = encode(data_type, FULL_SCALE_INT);
      ATTR_OFFSET_B: get_data = {{16{offset_b[15]}}, offset_b};
      ATTR_OFFSET_A: get_data = {{16{offset_a[15]}}, offset_a};
      ATTR_GAIN: get_data = {{16{gain[15]}}, gain};
      ATTR_ALARM_HI: get_data = {{16{trip[0][15]}}, trip[0]};
      ATTR_ALARM_LO: get_data = {{16{trip[1][15]}}, trip[1]};
      ATTR_WARN_HI: get_data = {{16{trip[2][15]}}, trip[2]};
      ATTR_WARN_LO: get_data = {{16{trip[3][15]}}, trip[3]};
      ATTR_HYST: get_data = {16'h0000, hyst};
      ATTR_SETTLE: get_data = {16'h0000, settle};
      ATTR_SAFE_STATE: get_data = {24'h00_0000, safe_state};
      ATTR_SAFE_VALUE: get_data = {{16{safe_value[15]}}, safe_value};
      default: begin
        get_data = 32'h0000_0000;
        get_code = RESP_ATTR_UNSUP;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Services
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      data_type <= DTYPE_INT;
      units <= UNITS_COUNTS;
      alarm_en <= 1'b0;
      warn_en <= 1'b0;
      offset_a <= 16'sh0000;
      offset_b <= 16'sh0000;
      gain <= GAIN_UNITY;
      trip[0] <= TRIP_HI_RESET;
      trip[1] <= TRIP_LO_RESET;
      trip[2] <= TRIP_HI_RESET;
      trip[3] <= TRIP_LO_RESET;
      hyst <= 16'h0000;
      settle <= 16'h0000;
      safe_state <= SAFE_ZERO;
      safe_value <= 16'sh0000;
      resp_code <= RESP_OK;
      resp_data <= 32'h0000_0000;
    end else if (cmd_write) begin
      resp_data <= 32'h0000_0000;
      resp_code <= RESP_OK;
      case (cmd_code)
        SVC_GET: begin
          resp_data <= get_data;
          resp_code <= get_code;
        end
        SVC_SET: begin
          case (cmd_attr)
            ATTR_DATA_TYPE: begin
              if (!OBJ_IDLE || IO_CONN_EST) begin
                resp_code <= RESP_STATE_CONFLICT;
              end else if (svc_wdata[7:0] != DTYPE_INT && svc_wdata[7:0] != DTYPE_REAL) begin
                resp_code <= RESP_BAD_VALUE;
              end else begin
                data_type <= svc_wdata[7:0];
              end
            end
            ATTR_UNITS: begin
              if (!OBJ_IDLE) begin
                resp_code <= RESP_STATE_CONFLICT;
              end else if (svc_wdata[15:0] != UNITS_COUNTS && svc_wdata[15:0] != UNITS_SCCM) begin
                resp_code <= RESP_BAD_VALUE;
              end else begin
                units <= svc_wdata[15:0];
              end
            end
            ATTR_ALARM_EN: alarm_en <= svc_wdata[0];
            ATTR_WARN_EN: warn_en <= svc_wdata[0];
            ATTR_OFFSET_B: offset_b <= svc_wdata[15:0];
            ATTR_OFFSET_A: offset_a <= svc_wdata[15:0];
            ATTR_GAIN: gain <= svc_wdata[15:0];
            ATTR_ALARM_HI: trip[0] <= svc_wdata[15:0];
            ATTR_ALARM_LO: trip[1] <= svc_wdata[15:0];
            ATTR_WARN_HI: trip[2] <= svc_wdata[15:0];
            ATTR_WARN_LO: trip[3] <= svc_wdata[15:0];
            ATTR_HYST: hyst <= svc_wdata[15:0];
            ATTR_SETTLE: settle <= svc_wdata[15:0];
            ATTR_SAFE_STATE: begin
              if (svc_wdata[7:0] > SAFE_USE_VALUE) begin
                resp_code <= RESP_BAD_VALUE;
              end else begin
                safe_state <= svc_wdata[7:0];
              end
            end
            ATTR_SAFE_VALUE: safe_value <= svc_wdata[15:0];
            ATTR_READ_VALID, ATTR_VALUE, ATTR_STATUS, ATTR_FULL_SCALE: begin
              resp_code <= RESP_NOT_SETTABLE;
            end
            default: resp_code <= RESP_ATTR_UNSUP;
          endcase
        end
        SVC_ZERO_TRIM: begin
          // Only the output offset moves, so gain never scales the trim step
          offset_b <= sat16(34'(offset_b) + 34'($signed(svc_wdata[15:0])) - 34'(corrected));
        end
        SVC_GAIN_TRIM: resp_code <= RESP_SVC_UNSUP;
        default: resp_code <= RESP_SVC_UNSUP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_status_reserved_zero: assert property (STATUS_OUT[7:4] == 4'h0)
    else $error("status reserved bits not zero");
  a_status_bits_map: assert property (##1 STATUS_OUT[3:0] == $past(flag))
    else $error("status bits do not follow exceptions");
  a_dtype_locked: assert property (cmd_write && cmd_code == SVC_SET && cmd_attr == ATTR_DATA_TYPE
      && (!OBJ_IDLE || IO_CONN_EST) |=> $stable(data_type) && resp_code == RESP_STATE_CONFLICT)
    else $error("data type changed outside idle or while connected");
  a_units_bad_kept: assert property (cmd_write && cmd_code == SVC_SET && cmd_attr == ATTR_UNITS
      && OBJ_IDLE && svc_wdata[15:0] != UNITS_COUNTS && svc_wdata[15:0] != UNITS_SCCM
      |=> $stable(units) && resp_code == RESP_BAD_VALUE)
    else $error("unsupported units accepted");
  a_units_idle_only: assert property (!OBJ_IDLE |=> $stable(units))
    else $error("units changed outside idle");
  a_exec_value: assert property (OBJ_EXECUTING |=> reported == $past(corrected))
    else $error("reported value is not the corrected value");
  a_safe_zero: assert property (!OBJ_EXECUTING && safe_state == SAFE_ZERO |=> reported == 16'sh0000)
    else $error("safe zero not applied");
  a_safe_value_used: assert property (!OBJ_EXECUTING && safe_state == SAFE_USE_VALUE
      |=> reported == $past(safe_value))
    else $error("safe value not applied");
  a_high_set_cause: assert property ($rose(flag[0]) |-> $past(beyond[0] && dwell[0] >= settle))
    else $error("high alarm set without settled excursion");
  a_high_clear_cause: assert property ($fell(flag[0]) && $past(alarm_en)
      |-> $past(clear_ok[0] && dwell[0] >= settle))
    else $error("high alarm cleared without settled recovery");
  a_low_set_cause: assert property ($rose(flag[1]) |-> $past(beyond[1]))
    else $error("low alarm set without low excursion");
  a_low_clear_cause: assert property ($fell(flag[1]) && $past(alarm_en) |-> $past(clear_ok[1]))
    else $error("low alarm cleared inside hysteresis band");
  a_gain_trim_refused: assert property (cmd_write && cmd_code == SVC_GAIN_TRIM
      |=> resp_code == RESP_SVC_UNSUP && $stable(gain))
    else $error("gain trim not refused");
  a_zero_trim_target: assert property (cmd_write && cmd_code == SVC_ZERO_TRIM
      && corrected != 16'sh7fff && corrected != 16'sh8000
      ##1 $stable(SENSOR_READING) && $stable(offset_a) && $stable(gain)
      |-> corrected == $past(svc_wdata[15:0]))
    else $error("zero trim missed target");

endmodule : sensor_value_alarm

`default_nettype wire

// ===== src/sensor_value_pkg.sv
// Purpose: Shared constants for the sensor-value object with alarm logic.
// Assumes: APB register access, 50 MHz device clock, 16-bit signed readings.
// Notes: Constants below are shared by the design and the bench.
package sensor_value_pkg;

  // ----------------------------------------------------------------
  // Service codes and answers
  // ----------------------------------------------------------------
  localparam logic [7:0] SVC_GET = 8'h0e;
  localparam logic [7:0] SVC_SET = 8'h10;
  localparam logic [7:0] SVC_ZERO_TRIM = 8'h4b;
  localparam logic [7:0] SVC_GAIN_TRIM = 8'h4c;
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_SVC_UNSUP = 8'h08;
  localparam logic [7:0] RESP_BAD_VALUE = 8'h09;
  localparam logic [7:0] RESP_STATE_CONFLICT = 8'h0c;
  localparam logic [7:0] RESP_NOT_SETTABLE = 8'h0e;
  localparam logic [7:0] RESP_ATTR_UNSUP = 8'h14;

  // ----------------------------------------------------------------
  // Attribute identifiers
  // ----------------------------------------------------------------
  localparam logic [7:0] ATTR_DATA_TYPE = 8'h03;
  localparam logic [7:0] ATTR_UNITS = 8'h04;
  localparam logic [7:0] ATTR_READ_VALID = 8'h05;
  localparam logic [7:0] ATTR_VALUE = 8'h06;
  localparam logic [7:0] ATTR_STATUS = 8'h07;
  localparam logic [7:0] ATTR_ALARM_EN = 8'h08;
  localparam logic [7:0] ATTR_WARN_EN = 8'h09;
  localparam logic [7:0] ATTR_FULL_SCALE = 8'h0a;
  localparam logic [7:0] ATTR_OFFSET_B = 8'h10;
  localparam logic [7:0] ATTR_OFFSET_A = 8'h11;
  localparam logic [7:0] ATTR_GAIN = 8'h12;
  localparam logic [7:0] ATTR_ALARM_HI = 8'h13;
  localparam logic [7:0] ATTR_ALARM_LO = 8'h14;
  localparam logic [7:0] ATTR_WARN_HI = 8'h15;
  localparam logic [7:0] ATTR_WARN_LO = 8'h16;
  localparam logic [7:0] ATTR_HYST = 8'h17;
  localparam logic [7:0] ATTR_SETTLE = 8'h18;
  localparam logic [7:0] ATTR_SAFE_STATE = 8'h19;
  localparam logic [7:0] ATTR_SAFE_VALUE = 8'h1a;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DTYPE_INT = 8'hc3;
  localparam logic [7:0] DTYPE_REAL = 8'hca;
  localparam logic [15:0] UNITS_COUNTS = 16'h1001;
  localparam logic [15:0] UNITS_SCCM = 16'h1400;
  localparam logic [7:0] SAFE_ZERO = 8'h00;
  localparam logic [7:0] SAFE_FULL = 8'h01;
  localparam logic [7:0] SAFE_HOLD = 8'h02;
  localparam logic [7:0] SAFE_USE_VALUE = 8'h03;
  localparam logic [15:0] GAIN_UNITY = 16'h0100;
  localparam int GAIN_FRAC_BITS = 8;
  localparam logic [15:0] FULL_SCALE_INT = 16'h7fff;
  localparam logic [15:0] TRIP_HI_RESET = 16'h7fff;
  localparam logic [15:0] TRIP_LO_RESET = 16'h8000;

  // ----------------------------------------------------------------
  // APB byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_SVC_CMD = 12'h000;
  localparam logic [11:0] OFF_SVC_WDATA = 12'h004;
  localparam logic [11:0] OFF_SVC_RESP = 12'h008;
  localparam logic [11:0] OFF_SVC_RDATA = 12'h00c;
  localparam logic [11:0] OFF_VALUE = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_UNIT_NS = 1000000;
  localparam int SETTLE_TICK_CYCLES = SETTLE_UNIT_NS / CLK_PERIOD_NS;

endpackage : sensor_value_pkg

// ===== testbench/svc_master.sv
// Purpose: Fieldbus master model that posts services to the block over APB.
// Assumes: Slave raises PREADY at some edge; the bench watchdog bounds the wait.
// Notes: Signals move only by non-blocking assignment just after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module svc_master
  import sensor_value_pkg::*;
(
  input wire logic mclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // One transfer
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a live one
    paddr <= ~addr;
    pwdata <= ~wdata;
  endtask : xfer

  // ----------------------------------------------------------------
  // One service: argument, command, then answer
  // ----------------------------------------------------------------
  task automatic service(input logic [7:0] code, input logic [7:0] attr,
                         input logic [31:0] arg, output logic [7:0] resp,
                         output logic [31:0] rdata);
    logic [31:0] d;
    logic e;
    xfer(1'b1, OFF_SVC_WDATA, arg, d, e);
    xfer(1'b1, OFF_SVC_CMD, {16'h0000, attr, code}, d, e);
    xfer(1'b0, OFF_SVC_RESP, 32'h0000_0000, d, e);
    resp = d[7:0];
    xfer(1'b0, OFF_SVC_RDATA, 32'h0000_0000, rdata, e);
  endtask : service
endmodule : svc_master

`default_nettype wire

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the sensor value and alarm block.
// Assumes: Settling tick shortened to 4 cycles; services posted by svc_master.
// Notes: Service rows first, then value, safe-state, alarm and trim cases.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import sensor_value_pkg::*;
  typedef struct packed {
    logic [1:0] st;
    logic [7:0] code;
    logic [7:0] attr;
    logic [15:0] arg;
    logic [7:0] resp;
    logic [31:0] rd;
  } row_t;
  // ----------------------------------------------------------------
  // Tables; st is {idle, connected}
  // ----------------------------------------------------------------
  localparam row_t ROWS [15] = '{
    '{2'b10, SVC_SET, ATTR_UNITS, 16'h1400, RESP_OK, 32'h0},
    '{2'b10, SVC_GET, ATTR_UNITS, 16'h0, RESP_OK, 32'h1400},
    '{2'b10, SVC_SET, ATTR_UNITS, 16'h1234, RESP_BAD_VALUE, 32'h0},
    '{2'b10, SVC_GET, ATTR_UNITS, 16'h0, RESP_OK, 32'h1400},
    '{2'b00, SVC_SET, ATTR_UNITS, 16'h1001, RESP_STATE_CONFLICT, 32'h0},
    '{2'b00, SVC_SET, ATTR_DATA_TYPE, 16'h00ca, RESP_STATE_CONFLICT, 32'h0},
    '{2'b11, SVC_SET, ATTR_DATA_TYPE, 16'h00ca, RESP_STATE_CONFLICT, 32'h0},
    '{2'b10, SVC_GET, ATTR_DATA_TYPE, 16'h0, RESP_OK, 32'h00c3},
    '{2'b10, SVC_SET, ATTR_DATA_TYPE, 16'h00ca, RESP_OK, 32'h0},
    '{2'b10, SVC_GET, ATTR_DATA_TYPE, 16'h0, RESP_OK, 32'h00ca},
    '{2'b10, SVC_SET, ATTR_VALUE, 16'h1, RESP_NOT_SETTABLE, 32'h0},
    '{2'b10, SVC_GET, ATTR_STATUS, 16'h0, RESP_OK, 32'h0},
    '{2'b10, SVC_GET, ATTR_READ_VALID, 16'h0, RESP_OK, 32'h1},
    '{2'b10, SVC_GAIN_TRIM, ATTR_VALUE, 16'h0, RESP_SVC_UNSUP, 32'h0},
    '{2'b10, SVC_SET, ATTR_SAFE_STATE, 16'h4, RESP_BAD_VALUE, 32'h0}
  };
  localparam logic [23:0] CFG [12] = '{
    {ATTR_OFFSET_A, 16'h0003}, {ATTR_GAIN, 16'h0200}, {ATTR_OFFSET_B, 16'hfffb},
    {ATTR_SAFE_VALUE, 16'hfff9}, {ATTR_ALARM_EN, 16'h0001}, {ATTR_WARN_EN, 16'h0001},
    {ATTR_ALARM_HI, 16'h001f}, {ATTR_WARN_HI, 16'h001f}, {ATTR_ALARM_LO, 16'h000b},
    {ATTR_WARN_LO, 16'h000b}, {ATTR_HYST, 16'h0002}, {ATTR_SETTLE, 16'h0002}
  };
  // Reading, cycles held, status expected; value is twice the reading plus one
  localparam logic [31:0] AL [13] = '{
    {16'h000a, 8'h10, 8'h00}, {16'h0010, 8'h02, 8'h00}, {16'h000a, 8'h10, 8'h00},
    {16'h000f, 8'h10, 8'h00}, {16'h0010, 8'h10, 8'h05}, {16'h000e, 8'h10, 8'h05},
    {16'h000d, 8'h02, 8'h05}, {16'h0010, 8'h10, 8'h05}, {16'h000d, 8'h10, 8'h00},
    {16'h0005, 8'h10, 8'h00}, {16'h0004, 8'h10, 8'h0a}, {16'h0006, 8'h10, 8'h0a},
    {16'h0007, 8'h10, 8'h00}
  };
  localparam logic [31:0] SAFE_EXP [4] = '{32'h0, 32'h7fff, 32'h15, 32'hffff_fff9};

  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic sensor_valid, obj_exec, obj_idle, io_conn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, value_out, rdat;
  logic [15:0] reading;
  logic [7:0] status_out, resp;
  int failures = 0;
  int n_checks = 0;

  sensor_value_alarm #(.TICK_CYCLES(4)) u_sensor_value_alarm (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SENSOR_READING(reading), .SENSOR_VALID(sensor_valid), .OBJ_EXECUTING(obj_exec),
    .OBJ_IDLE(obj_idle), .IO_CONN_EST(io_conn), .VALUE_OUT(value_out),
    .STATUS_OUT(status_out)
  );
  svc_master u_svc_master (
    .mclk(mclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic svc(input logic [7:0] code, input logic [7:0] attr, input logic [15:0] arg);
    u_svc_master.service(code, attr, {{16{arg[15]}}, arg}, resp, rdat);
  endtask : svc

  task automatic put(input logic [15:0] x, input int n);
    @(posedge mclk);
    reading <= x;
    repeat (n) @(posedge mclk);
  endtask : put

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  initial begin
    repeat (6000) @(posedge mclk);
    failures++;
    give_verdict();
  end

  initial begin
    rst_n <= 1'b0;
    {obj_exec, obj_idle, io_conn, sensor_valid} <= 4'b0101;
    reading <= 16'h0000;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    check("status after reset", 32'h0, 32'(status_out));
    for (int i = 0; i < 15; i++) begin
      {obj_idle, io_conn} <= ROWS[i].st;
      svc(ROWS[i].code, ROWS[i].attr, ROWS[i].arg);
      check("response", 32'(ROWS[i].resp), 32'(resp));
      if (ROWS[i].code == SVC_GET) check("attribute", ROWS[i].rd, rdat);
    end
    for (int i = 0; i < 12; i++) begin
      svc(SVC_SET, CFG[i][23:16], CFG[i][15:0]);
      check("config response", 32'(RESP_OK), 32'(resp));
    end
    $display("test services done");
    {obj_exec, obj_idle} <= 2'b10;
    put(16'h000a, 4);
    check("real value", 32'h41a8_0000, value_out);
    {obj_exec, obj_idle} <= 2'b01;
    svc(SVC_SET, ATTR_DATA_TYPE, 16'h00c3);
    {obj_exec, obj_idle} <= 2'b10;
    put(16'h000a, 4);
    check("int value", 32'h15, value_out);
    $display("test value path done");
    for (int c = 0; c < 4; c++) begin
      svc(SVC_SET, ATTR_SAFE_STATE, 16'(c));
      obj_exec <= 1'b0;
      put(16'h000a, 4);
      check("safe value", SAFE_EXP[c], value_out);
      obj_exec <= 1'b1;
    end
    $display("test safe state done");
    for (int i = 0; i < 13; i++) begin
      put(AL[i][31:16], int'(AL[i][15:8]));
      check("status", 32'(AL[i][7:0]), 32'(status_out));
    end
    $display("test alarms done");
    put(16'h000a, 4);
    // Target is what the gauge should truly show at this moment
    svc(SVC_ZERO_TRIM, ATTR_VALUE, 16'h0064);
    check("trim response", 32'(RESP_OK), 32'(resp));
    put(16'h000a, 4);
    check("trimmed value", 32'h64, value_out);
    u_svc_master.xfer(1'b0, 12'h020, 32'h0, rdat, err);
    check("unmapped error", 32'h1, 32'(err));
    check("unmapped data", 32'h0, rdat);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    check("value after reset", 32'h0a, value_out);
    check("status after second reset", 32'h0, 32'(status_out));
    svc(SVC_GET, ATTR_OFFSET_B, 16'h0);
    check("offset after reset", 32'h0, rdat);
    $display("test trim and unmapped done");
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
